/* core/nvc_mux_i2c.v */
// serial-bus slave driving six open-drain outputs from five sources
//
// Notes on behaviour
// - slave address compares two strap pins, four devices per bus
// - address lsb one means read, zero means write
// - each accepted command byte is held; selection codes F8 to FE read back as themselves
// - only defined codes are acknowledged, reserved codes are not
// - codes 00 to 03 address stored bytes 0 to 3, read and write
// - code FF addresses read-only external input levels
// - code F8 routes stored byte 0 to the outputs
// - code FC routes stored byte 1 to the outputs
// - codes F9 and FB route stored byte 2 to the outputs
// - code FD routes stored byte 3 to the outputs; FF hands back to the select pin
// - five sources; codes FA and FE select the external inputs
// - bus selection codes override the select pin; storage codes leave it; hand-back returns it
// - in pin mode the select pin picks external inputs or stored
// - four independent six-bit stored bytes, read and write
// - six external inputs sampled, six outputs carry selection
// - outputs only pull low or release, never drive high
// - stored bytes survive power loss
// - bus clock up to 400 kHz; the bench master runs far above it, 64 ns per bit
// - write guard high: address and command acked, data refused
// - stored byte written only at the following stop, if unguarded
// - after a storage write, own address refused for 3.6 ms
// - after reset with select pin low, outputs show stored byte 0
`timescale 1ns/1ps
`include "nvc_defines.vh"
module nvc_mux_i2c #(
   parameter       PROG_CYCLES = `NVC_PROG_CYCLES,
   parameter [4:0] DEV_ADDR_HI = `NVC_DEV_ADDR_HI
) (
   input  wire       mclk,
   input  wire       rst_n,
   input  wire       scl,
   input  wire       sdaIn,
   output wire       sdaOut,
   output wire       sdaOe,
   input  wire       addr_strap_low,
   input  wire       addr_strap_high,
   input  wire       writeGuard,
   input  wire       muxSelect,
   input  wire [5:0] extIn,
   output wire [5:0] muxOut,
   output wire [5:0] muxOutOe
);
   localparam [4:0] ST_IDLE  = 5'b00001;
   localparam [4:0] ST_RX    = 5'b00010;
   localparam [4:0] ST_ACK   = 5'b00100;
   localparam [4:0] ST_TX    = 5'b01000;
   localparam [4:0] ST_RXACK = 5'b10000;

   localparam [1:0] PH_ADDR = 2'h0;
   localparam [1:0] PH_CMD  = 2'h1;
   localparam [1:0] PH_DATA = 2'h2;

   wire [11:0] syncOut;
   wire        sclS;
   wire        sdaS;
   wire        strapLowS;
   wire        strapHighS;
   wire        guardS;
   wire        selPinS;
   wire [5:0]  extS;
   wire [23:0] nvData;
   wire        progBusy;

   reg         sclD_ff;
   reg         sdaD_ff;
   reg [4:0]   state_ff;
   reg [3:0]   bitCnt_ff;
   reg [7:0]   shift_ff;
   reg [7:0]   txSh_ff;
   reg [1:0]   phase_ff;
   reg         readMode_ff;
   reg         sdaOe_ff;
   reg [7:0]   ctrl_ff;
   reg [2:0]   burst_ff;
   reg [23:0]  pend_ff;
   reg [3:0]   pendMask_ff;
   reg         commit_ff;
   reg         override_ff;
   reg [2:0]   srcSel_ff;
   reg [5:0]   outLow_ff;

   integer     i;

   // true for codes that address a stored byte
   function isStore;
      input [7:0] c;
      begin
         isStore = (c[7:2] == `NVC_CMD_STORE_TOP);
      end
   endfunction

   // storage addresses, the input read code and the selection codes
   function cmdValid;
      input [7:0] c;
      begin
         cmdValid = isStore(c) || (c[7:3] == `NVC_CMD_MUX_TOP);
      end
   endfunction

   // source chosen by a command, in fixed priority order
   function [2:0] selDecode;
      input [7:0] c;
      begin
         if (c == `NVC_CMD_SEL_BYTE0) begin
            selDecode = `NVC_SRC_BYTE0;
         end else if (c == `NVC_CMD_SEL_BYTE1) begin
            selDecode = `NVC_SRC_BYTE1;
         end else if (c == `NVC_CMD_EXT_READ) begin
            selDecode = `NVC_SRC_PIN;
         end else if (c[7:3] == `NVC_CMD_MUX_TOP && !c[2] && c[0]) begin
            selDecode = `NVC_SRC_BYTE2;
         end else if (c[7:2] == {`NVC_CMD_MUX_TOP, 1'b1} && c[0]) begin
            selDecode = `NVC_SRC_BYTE3;
         end else if (c[7:3] == `NVC_CMD_MUX_TOP && c[1:0] == 2'b10) begin
            selDecode = `NVC_SRC_EXT;
         end else begin
            selDecode = `NVC_SRC_NONE;
         end
      end
   endfunction

   // one stored byte out of the flat store bus
   function [5:0] nvByte;
      input [23:0] d;
      input [1:0]  idx;
      begin
         case (idx)
            2'h0:    nvByte = d[5:0];
            2'h1:    nvByte = d[11:6];
            2'h2:    nvByte = d[17:12];
            default: nvByte = d[23:18];
         endcase
      end
   endfunction

   nvc_sync #(
      .W       (`NVC_SYNC_W)
   ) u_sync (
      .mclk    (mclk),
      .rst_n   (rst_n),
      .asyncIn ({extIn, muxSelect, writeGuard, addr_strap_high,
                 addr_strap_low, sdaIn, scl}),
      .syncOut (syncOut)
   );

   assign sclS       = syncOut[0];
   assign sdaS       = syncOut[1];
   assign strapLowS  = syncOut[2];
   assign strapHighS = syncOut[3];
   assign guardS     = syncOut[4];
   assign selPinS    = syncOut[5];
   assign extS       = syncOut[11:6];

   nvc_nv_store #(
      .PROG_CYCLES (PROG_CYCLES)
   ) u_store (
      .mclk        (mclk),
      .rst_n       (rst_n),
      .wrEn        (commit_ff),
      .wrMask      (pendMask_ff),
      .wrData      (pend_ff),
      .rdData      (nvData),
      .progBusy    (progBusy)
   );

   wire sclRise   = sclS & ~sclD_ff;
   wire sclFall   = ~sclS & sclD_ff;
   wire startCond = sclS & sclD_ff & sdaD_ff & ~sdaS;
   wire stopCond  = sclS & sclD_ff & ~sdaD_ff & sdaS;

   // own address, strap pins in the two low address bits
   wire addrHit = (shift_ff[7:1] == {DEV_ADDR_HI, strapHighS, strapLowS})
                  && !progBusy;

   wire storeOk = isStore(ctrl_ff) && !guardS;

   // byte returned on a read follows the held command
   wire [7:0] txByte = (ctrl_ff == `NVC_CMD_EXT_READ) ? {2'b00, extS} :
                       isStore(ctrl_ff) ?
                       {2'b00, nvByte(nvData, ctrl_ff[1:0])} :
                       ctrl_ff;

   wire loadTx = sclFall && ((state_ff == ST_ACK && readMode_ff) ||
                             state_ff == ST_RXACK);

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sclD_ff     <= 1'b1;
         sdaD_ff     <= 1'b1;
         state_ff    <= ST_IDLE;
         bitCnt_ff   <= 4'h0;
         shift_ff    <= 8'h00;
         txSh_ff     <= 8'h00;
         phase_ff    <= PH_ADDR;
         readMode_ff <= 1'b0;
         sdaOe_ff    <= 1'b0;
         ctrl_ff     <= `NVC_CTRL_RESET;
         burst_ff    <= 3'h0;
         pend_ff     <= 24'h000000;
         pendMask_ff <= 4'h0;
         commit_ff   <= 1'b0;
         override_ff <= 1'b0;
         srcSel_ff   <= `NVC_SRC_BYTE0;
      end else begin
         sclD_ff   <= sclS;
         sdaD_ff   <= sdaS;
         commit_ff <= 1'b0;
         if (commit_ff) begin
            pendMask_ff <= 4'h0;
         end
         if (startCond) begin
            state_ff  <= ST_RX;
            phase_ff  <= PH_ADDR;
            bitCnt_ff <= 4'h0;
            sdaOe_ff  <= 1'b0;
            pendMask_ff <= 4'h0;
         end else if (stopCond) begin
            state_ff <= ST_IDLE;
            sdaOe_ff <= 1'b0;
            if (pendMask_ff != 4'h0 && !guardS) begin
               commit_ff <= 1'b1;
            end else begin
               pendMask_ff <= 4'h0;
            end
         end else if (loadTx) begin
            state_ff  <= ST_TX;
            txSh_ff   <= txByte;
            sdaOe_ff  <= ~txByte[7];
            bitCnt_ff <= 4'h0;
            if (isStore(ctrl_ff)) begin
               ctrl_ff[1:0] <= ctrl_ff[1:0] + 2'h1;
            end
         end else begin
            case (state_ff)
               ST_IDLE: begin
                  sdaOe_ff <= 1'b0;
               end
               ST_RX: begin
                  if (sclRise) begin
                     shift_ff  <= {shift_ff[6:0], sdaS};
                     bitCnt_ff <= bitCnt_ff + 4'h1;
                  end else if (sclFall && bitCnt_ff == 4'h8) begin
                     bitCnt_ff <= 4'h0;
                     state_ff  <= ST_ACK;
                     case (phase_ff)
                        PH_ADDR: begin
                           readMode_ff <= shift_ff[`NVC_RW_BIT];
                           sdaOe_ff    <= addrHit;
                           if (!addrHit) begin
                              state_ff <= ST_IDLE;
                           end
                        end
                        PH_CMD: begin
                           sdaOe_ff <= cmdValid(shift_ff);
                           if (!cmdValid(shift_ff)) begin
                              state_ff <= ST_IDLE;
                           end else begin
                              ctrl_ff  <= shift_ff;
                              burst_ff <= 3'h0;
                              if (selDecode(shift_ff) == `NVC_SRC_PIN) begin
                                 override_ff <= 1'b0;
                              end else if (selDecode(shift_ff) !=
                                           `NVC_SRC_NONE) begin
                                 override_ff <= 1'b1;
                                 srcSel_ff   <= selDecode(shift_ff);
                              end
                           end
                        end
                        default: begin
                           if (storeOk && burst_ff != `NVC_MAX_BURST) begin
                              sdaOe_ff <= 1'b1;
                              burst_ff <= burst_ff + 3'h1;
                              ctrl_ff[1:0] <= ctrl_ff[1:0] + 2'h1;
                              for (i = 0; i < 4; i = i + 1) begin
                                 if (ctrl_ff[1:0] == i[1:0]) begin
                                    pend_ff[i*6 +: 6] <= shift_ff[5:0];
                                    pendMask_ff[i]    <= 1'b1;
                                 end
                              end
                           end else begin
                              // refused data byte, nothing is programmed
                              sdaOe_ff    <= 1'b0;
                              pendMask_ff <= 4'h0;
                              state_ff    <= ST_IDLE;
                           end
                        end
                     endcase
                  end
               end
               ST_ACK: begin
                  if (sclFall) begin
                     sdaOe_ff <= 1'b0;
                     state_ff <= ST_RX;
                     if (phase_ff == PH_ADDR) begin
                        phase_ff <= PH_CMD;
                     end else begin
                        phase_ff <= PH_DATA;
                     end
                  end
               end
               ST_TX: begin
                  if (sclFall) begin
                     if (bitCnt_ff == 4'h7) begin
                        sdaOe_ff <= 1'b0;
                        state_ff <= ST_RXACK;
                     end else begin
                        sdaOe_ff  <= ~txSh_ff[6];
                        txSh_ff   <= {txSh_ff[6:0], 1'b0};
                        bitCnt_ff <= bitCnt_ff + 4'h1;
                     end
                  end
               end
               ST_RXACK: begin
                  // master not acknowledging ends the read
                  if (sclRise && sdaS) begin
                     state_ff <= ST_IDLE;
                  end
               end
               default: begin
                  state_ff <= ST_IDLE;
                  sdaOe_ff <= 1'b0;
               end
            endcase
         end
      end
   end

   // selected six-bit source
   reg [5:0] srcVal;
   always @* begin
      srcVal = nvByte(nvData, 2'h0);
      if (override_ff) begin
         case (srcSel_ff)
            `NVC_SRC_EXT: srcVal = extS;
            default:      srcVal = nvByte(nvData, srcSel_ff[1:0]);
         endcase
      end else if (selPinS) begin
         srcVal = extS;
      end else begin
         srcVal = nvByte(nvData, 2'h0);
      end
   end

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         outLow_ff <= 6'h00;
      end else begin
         outLow_ff <= ~srcVal;
      end
   end

   // open-drain: data always low, enable pulls the line down
   assign muxOut   = 6'h00;
   assign muxOutOe = outLow_ff;
   assign sdaOut   = 1'b0;
   assign sdaOe    = sdaOe_ff;
endmodule

/* core/nvc_defines.vh */
// constants for the configuration mux serial slave
`ifndef NVC_DEFINES_VH
`define NVC_DEFINES_VH

`define NVC_DATA_W          6
`define NVC_NUM_BYTES       4
`define NVC_SYNC_W          12

`define NVC_DEV_ADDR_HI     5'h0D
`define NVC_RW_BIT          0

`define NVC_CMD_EXT_READ    8'hFF
`define NVC_CMD_SEL_BYTE0   8'hF8
`define NVC_CMD_SEL_BYTE1   8'hFC
`define NVC_CMD_MUX_TOP     5'h1F
`define NVC_CMD_STORE_TOP   6'h00

`define NVC_SRC_BYTE0       3'h0
`define NVC_SRC_BYTE1       3'h1
`define NVC_SRC_BYTE2       3'h2
`define NVC_SRC_BYTE3       3'h3
`define NVC_SRC_EXT         3'h4
`define NVC_SRC_NONE        3'h5
`define NVC_SRC_PIN         3'h7

`define NVC_CTRL_RESET      8'h00
`define NVC_NV_DEFAULT      6'h00
`define NVC_MAX_BURST       3'h4

`define NVC_MCLK_PERIOD_NS  8
`define NVC_PROG_TIME_NS    3600000
`define NVC_PROG_CYCLES     ((`NVC_PROG_TIME_NS + `NVC_MCLK_PERIOD_NS - 1) \
                             / `NVC_MCLK_PERIOD_NS)
`define NVC_PROG_CNT_W      20

`endif

/* core/nvc_sync.v */
// two-stage synchroniser for pins from outside the mclk domain
`timescale 1ns/1ps
module nvc_sync #(
   parameter W = 1
) (
   input  wire         mclk,
   input  wire         rst_n,
   input  wire [W-1:0] asyncIn,
   output wire [W-1:0] syncOut
);
   reg [W-1:0] stage1_ff;
   reg [W-1:0] stage2_ff;

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         stage1_ff <= {W{1'b0}};
         stage2_ff <= {W{1'b0}};
      end else begin
         stage1_ff <= asyncIn;
         stage2_ff <= stage1_ff;
      end
   end

   assign syncOut = stage2_ff;
endmodule

/* core/nvc_nv_store.v */
// four retained configuration bytes with a programming busy timer
`timescale 1ns/1ps
`include "nvc_defines.vh"
module nvc_nv_store #(
   parameter PROG_CYCLES = `NVC_PROG_CYCLES
) (
   input  wire        mclk,
   input  wire        rst_n,
   input  wire        wrEn,
   input  wire [3:0]  wrMask,
   input  wire [23:0] wrData,
   output wire [23:0] rdData,
   output wire        progBusy
);
   reg [5:0]                 mem [0:3];
   reg [`NVC_PROG_CNT_W-1:0] progCnt_ff;
   integer                   i;
   integer                   j;

   // retained array: not touched by reset, factory default zero
   initial begin
      for (j = 0; j < 4; j = j + 1) begin
         mem[j] = `NVC_NV_DEFAULT;
      end
   end

   always @(posedge mclk) begin
      for (i = 0; i < 4; i = i + 1) begin
         if (wrEn && wrMask[i]) begin
            mem[i] <= wrData[i*6 +: 6];
         end
      end
   end

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         progCnt_ff <= {`NVC_PROG_CNT_W{1'b0}};
      end else if (wrEn) begin
         progCnt_ff <= PROG_CYCLES[`NVC_PROG_CNT_W-1:0];
      end else if (progCnt_ff != {`NVC_PROG_CNT_W{1'b0}}) begin
         progCnt_ff <= progCnt_ff - 1'b1;
      end
   end

   assign rdData   = {mem[3], mem[2], mem[1], mem[0]};
   assign progBusy = (progCnt_ff != {`NVC_PROG_CNT_W{1'b0}});
endmodule

/* tb/nvc_mux_i2c_asserts.sv */
// concurrent checks on the configuration mux slave ports
`timescale 1ns/1ps
module nvc_mux_i2c_asserts (
   input wire logic       mclk,
   input wire logic       rst_n,
   input wire logic       scl,
   input wire logic       sdaIn,
   input wire logic       sdaOut,
   input wire logic       sdaOe,
   input wire logic       addr_strap_low,
   input wire logic       addr_strap_high,
   input wire logic       writeGuard,
   input wire logic       muxSelect,
   input wire logic [5:0] extIn,
   input wire logic [5:0] muxOut,
   input wire logic [5:0] muxOutOe
);
   logic       ackSeen_ff;
   logic [6:0] pullCnt_ff;
   logic [4:0] sclHighCnt_ff;
   // no acknowledge since reset means no bus override can exist
   wire        ackSeen = ackSeen_ff | sdaOe;

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ackSeen_ff <= 1'b0;
         pullCnt_ff <= 7'h00;
         sclHighCnt_ff <= 5'h00;
      end else begin
         ackSeen_ff <= ackSeen;
         pullCnt_ff <= !sdaOe ? 7'h00
                       : pullCnt_ff + {6'h00, pullCnt_ff != 7'h7F};
         sclHighCnt_ff <= !scl ? 5'h00
                          : sclHighCnt_ff + {4'h0, sclHighCnt_ff != 5'h1F};
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   chk_out_low_only: assert property (
      muxOut == 6'h00) else $error("mux output driven high");
   chk_sda_low_only: assert property (
      sdaOut == 1'b0) else $error("bus data driven high");
   chk_reset_release: assert property (
      $rose(rst_n) |-> muxOutOe == 6'h00 && !sdaOe)
      else $error("pins not released in reset");
   chk_pin_ext_mode: assert property (
      (!ackSeen && muxSelect && $stable(extIn) && $stable(muxSelect)) [*5]
      |-> muxOutOe == ~extIn) else $error("pin mode not showing inputs");
   chk_source_holds: assert property (
      ($stable(scl) && $stable(sdaIn) && $stable(extIn)
       && $stable(muxSelect)) [*8] |-> $stable(muxOutOe))
      else $error("output source changed without cause");
   chk_ack_on_low: assert property (
      $rose(sdaOe) |-> !scl) else $error("data pulled while clock high");
   chk_pull_bounded: assert property (
      sdaOe |-> pullCnt_ff <= 7'h50) else $error("data held low too long");
   chk_idle_released: assert property (
      sclHighCnt_ff >= 5'h0C |-> !sdaOe) else $error("data held in idle");
endmodule

bind nvc_mux_i2c nvc_mux_i2c_asserts u_chk (
   .mclk(mclk), .rst_n(rst_n), .scl(scl), .sdaIn(sdaIn),
   .sdaOut(sdaOut), .sdaOe(sdaOe), .addr_strap_low(addr_strap_low),
   .addr_strap_high(addr_strap_high), .writeGuard(writeGuard),
   .muxSelect(muxSelect), .extIn(extIn), .muxOut(muxOut),
   .muxOutOe(muxOutOe)
);

/* tb/nvc_bus_master.sv */
// bus master model driving the serial clock and data lines
`timescale 1ns/1ps
module nvc_bus_master (
   input  wire logic mclk,
   input  wire logic sdaLine,
   output logic      scl,
   output logic      sdaPull
);
   // clock stands high between frames; 64 ns bit period
   initial begin
      scl = 1'b1;
      sdaPull = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic startC();
      tick(2);
      sdaPull <= 1'b0;
      tick(2);
      scl <= 1'b1;
      tick(4);
      sdaPull <= 1'b1;
      tick(4);
      scl <= 1'b0;
   endtask
   task automatic stopC();
      tick(2);
      sdaPull <= 1'b1;
      tick(2);
      scl <= 1'b1;
      tick(4);
      sdaPull <= 1'b0;
      tick(4);
   endtask
   // data set mid-low, line sampled mid-high
   task automatic bitX(input logic b, output logic r);
      tick(2);
      sdaPull <= !b;
      tick(2);
      scl <= 1'b1;
      tick(2);
      r = sdaLine;
      tick(2);
      scl <= 1'b0;
   endtask
   task automatic sendByte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bitX(d[i], r);
      end
      bitX(1'b1, r);
      ack = !r;
   endtask
   // a released answer on the last byte ends the read
   task automatic recvByte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bitX(1'b1, r);
         d[i] = r;
      end
      bitX(last, r);
   endtask
endmodule

/* tb/nvc_mux_i2c_test.sv */
// self-checking bench for the configuration mux serial slave
`timescale 1ns/1ps
`include "nvc_defines.vh"
module nvc_mux_i2c_test;
   localparam int PROG = 200;
   logic        mclk;
   logic        rst_n;
   logic        strapLo;
   logic        strapHi;
   logic        writeGuard;
   logic        muxSelect;
   logic [5:0]  extIn;
   wire         scl;
   wire         sdaPull;
   wire         sdaOe;
   wire         sdaLine;
   wire  [5:0]  muxOutOe;
   wire  [7:0]  outSeen = {2'h0, muxOutOe};
   logic [7:0]  wbuf [0:4];
   logic [7:0]  rbuf [0:3];
   logic [5:0]  nv [0:3];
   logic [6:0]  acks;
   logic [2:0]  src;
   logic [31:0] r;
   logic        ack;
   int          nFail;
   int          totalChecks;

   // released line rises through the pull-up
   assign sdaLine = !(sdaPull | sdaOe);

   nvc_mux_i2c #(.PROG_CYCLES(PROG)) DUT (
      .mclk(mclk), .rst_n(rst_n), .scl(scl), .sdaIn(sdaLine),
      .sdaOut(), .sdaOe(sdaOe), .addr_strap_low(strapLo),
      .addr_strap_high(strapHi), .writeGuard(writeGuard),
      .muxSelect(muxSelect), .extIn(extIn), .muxOut(),
      .muxOutOe(muxOutOe));
   nvc_bus_master mst (.mclk(mclk), .sdaLine(sdaLine), .scl(scl),
      .sdaPull(sdaPull));

   initial mclk = 1'b0;
   always #4 mclk = ~mclk;

   function automatic logic [6:0] devA();
      return {`NVC_DEV_ADDR_HI, strapHi, strapLo};
   endfunction
   // 7 stands for hand-back to the select pin
   function automatic logic [2:0] cmdSrc(input logic [7:0] c);
      if (c == 8'hF8) return 3'h0;
      if (c == 8'hFC) return 3'h1;
      if (c == 8'hFF) return 3'h7;
      if (c[0]) return c[2] ? 3'h3 : 3'h2;
      return 3'h4;
   endfunction
   function automatic logic [5:0] selVal(input logic [2:0] s);
      if (s == 3'h4 || (s == 3'h7 && muxSelect)) return extIn;
      return (s == 3'h7) ? nv[0] : nv[s[1:0]];
   endfunction
   function automatic logic [7:0] outE(input logic [2:0] s);
      return {2'h0, ~selVal(s)};
   endfunction
   // read-back after a selection code: the code, or input levels for FF
   function automatic logic [7:0] ctrlE(input logic [7:0] c);
      return (c == 8'hFF) ? {2'h0, extIn} : c;
   endfunction

   task automatic check(input string what, input logic [7:0] seen,
                        input logic [7:0] exp);
      totalChecks++;
      if (seen !== exp) begin
         nFail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wrTx(input logic [7:0] cmd, input int n);
      acks = 7'h00;
      mst.startC();
      mst.sendByte({devA(), 1'b0}, acks[0]);
      mst.sendByte(cmd, acks[1]);
      for (int k = 0; k < n; k++) begin
         mst.sendByte(wbuf[k], ack);
         acks[k + 2] = ack;
      end
      mst.stopC();
   endtask
   task automatic rdTx(input int n);
      mst.startC();
      mst.sendByte({devA(), 1'b1}, acks[0]);
      for (int k = 0; k < n; k++) begin
         mst.recvByte(k == n - 1, rbuf[k]);
      end
      mst.stopC();
   endtask
   task automatic readFrom(input logic [7:0] p);
      wrTx(p, 0);
      rdTx(4);
      for (int k = 0; k < 4; k++) begin
         check("stored", rbuf[k], {2'h0, nv[(p + k) % 4]});
      end
   endtask
   task automatic fill();
      for (int k = 0; k < 5; k++) begin
         r = $urandom;
         wbuf[k] = r[7:0];
      end
   endtask
   task automatic testDone();
      $display("checks %0d mismatches %0d", totalChecks, nFail);
      if (nFail == 0 && totalChecks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial begin
      repeat (40000) @(posedge mclk);
      nFail++;
      $display("watchdog expired");
      testDone();
   end

   initial begin
      rst_n = 1'b0;
      strapLo = 1'b0;
      strapHi = 1'b0;
      writeGuard = 1'b0;
      muxSelect = 1'b1;
      extIn = 6'h00;
      nFail = 0;
      totalChecks = 0;
      for (int k = 0; k < 4; k++) begin
         nv[k] = 6'h00;
      end
      r = $urandom(32'h87AFC90D);
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (8) @(posedge mclk);
      for (int i = 0; i < 6; i++) begin
         r = $urandom;
         muxSelect <= r[6];
         extIn <= r[5:0];
         repeat (8) @(posedge mclk);
         check("pin out", outSeen, outE(3'h7));
      end
      $display("test done: pin mode");
      for (int s = 0; s < 16; s++) begin
         strapLo <= s[0];
         strapHi <= s[1];
         repeat (4) @(posedge mclk);
         mst.startC();
         mst.sendByte({`NVC_DEV_ADDR_HI, s[3:2], 1'b1}, ack);
         if (ack) begin
            mst.recvByte(1'b1, rbuf[0]);
         end
         mst.stopC();
         check("addr ack", {7'h0, ack}, {7'h0, s[3:2] == s[1:0]});
      end
      r = $urandom;
      strapLo <= r[0];
      strapHi <= r[1];
      repeat (4) @(posedge mclk);
      $display("test done: address");
      for (int i = 0; i < 6; i++) begin
         r = (i == 0) ? 0 : (i == 1) ? 243 : $urandom_range(243);
         wrTx(8'h04 + r[7:0], 0);
         check("reserved", {7'h0, acks[1]}, 8'h00);
      end
      $display("test done: reserved codes");
      fill();
      wrTx(8'h00, 4);
      check("burst acks", {1'b0, acks}, 8'h3F);
      for (int k = 0; k < 4; k++) begin
         nv[k] = wbuf[k][5:0];
      end
      wrTx(8'h00, 0);
      check("busy addr", {7'h0, acks[0]}, 8'h00);
      repeat (PROG) @(posedge mclk);
      readFrom(8'h02);
      fill();
      wrTx(8'h01, 5);
      check("fifth byte", {7'h0, acks[6]}, 8'h00);
      readFrom(8'h01);
      fill();
      writeGuard <= 1'b1;
      wrTx(8'h03, 1);
      check("guard acks", {1'b0, acks}, 8'h03);
      writeGuard <= 1'b0;
      readFrom(8'h03);
      $display("test done: storage");
      for (int c = 8'hF8; c <= 8'hFF; c++) begin
         r = $urandom;
         muxSelect <= r[6];
         extIn <= r[5:0];
         wrTx(c[7:0], 1);
         check("sel acks", {1'b0, acks}, 8'h03);
         src = cmdSrc(c[7:0]);
         rdTx(1);
         check("ctrl", rbuf[0], ctrlE(c[7:0]));
         muxSelect <= !r[6];
         repeat (8) @(posedge mclk);
         check("sel", outSeen, outE(src));
      end
      $display("test done: selection");
      wrTx(8'hFD, 0);
      muxSelect <= 1'b0;
      rst_n <= 1'b0;
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (8) @(posedge mclk);
      check("por out", outSeen, outE(3'h7));
      readFrom(8'h00);
      $display("test done: reset");
      testDone();
   end
endmodule
